// file: design/hsi_pkg.sv
// Package of constants and carrier types for the HDLC status and interrupt logic.
package hsi_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  // Event status register, byte address.
  localparam logic [7:0] HDLC_EVENT_STATUS_OFS = 8'h38;
  // Interrupt enable register, byte address.
  localparam logic [7:0] HDLC_EVENT_ENABLE_OFS = 8'h3A;
  // Field positions within the status and enable words.
  localparam int TX_PACKET_DONE_BIT = 0;
  localparam int TX_LOW_LEVEL_BIT = 2;
  localparam int RX_HIGH_LEVEL_BIT = 4;
  localparam int RX_PACKET_BEGIN_BIT = 5;
  localparam int RX_PACKET_DONE_BIT = 6;
  localparam int TX_UNDERFLOW_BIT = 7;
  localparam int TX_LEVEL_LSB = 8;
  localparam int TX_VACANT_BIT = 12;
  localparam int RX_OVERFLOW_BIT = 13;
  localparam int RX_VACANT_BIT = 14;
  localparam int RX_ABORT_BIT = 15;
  // Bits that may raise the interrupt; also the writable enable bits.
  localparam logic [15:0] IRQ_CAPABLE_MASK = 16'hA0F5;
  // Enable register reset value.
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  // ---------------------------------------------------------------
  // FIFO geometry and thresholds
  // ---------------------------------------------------------------
  // Capacity of each FIFO in bytes.
  localparam logic [8:0] FIFO_CAPACITY = 9'h100;
  // Threshold for select code zero, and step between codes.
  localparam logic [8:0] THRESH_BASE = 9'h010;
  localparam logic [8:0] THRESH_STEP = 9'h020;
  // Top level code, covering the last 17 bytes.
  localparam logic [3:0] LEVEL_CODE_TOP = 4'hF;
  // Run length of ones that marks an abort.
  localparam logic [2:0] ABORT_RUN = 3'h7;
  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  // One host register access request.
  typedef struct packed {
    logic [7:0] addr;
    logic rd;
    logic wr;
    logic [15:0] wdata;
  } hsi_host_req_s;
  // Event strobes from the HDLC datapath, one-cycle pulses except the levels rx_bit and rx_in_packet.
  typedef struct packed {
    logic tx_push;
    logic tx_fetch;
    logic tx_fetch_last;
    logic rx_push;
    logic rx_pop;
    logic rx_open_byte;
    logic rx_msg_end;
    logic rx_bit_valid;
    logic rx_bit;
    logic rx_in_packet;
    logic rx_flag_seen;
  } hsi_events_s;
endpackage

// file: design/hsi_status_irq.sv
// HDLC event status, FIFO level tracking and interrupt request logic.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Latch tx packet end on last-tagged fetch or underrun.
// - Interrupt needs bit enable and summary enable.
// - Tx low flag live while below threshold.
// - Rx high flag live while above threshold.
// - Latch rx packet start; read clears it.
// - Latch rx packet end, any ending; read clears.
// - Underrun sends abort, latches; rearm after write.
// - Tx depth code in 16-byte steps, top 240-256.
// - Tx vacant flag high when tx FIFO empty.
// - Latch rx overrun; rearm after a FIFO read.
// - Rx vacant flag high when rx FIFO empty.
// - Seven ones during packet latch rx abort.
// - Valid flag needed before next abort flagged.
// - Depth code and vacant bits never raise interrupt.
// - Enable register at 3Ah, capable bits, reset zero.
// - Select codes pick 16 to 240 byte thresholds.
// - Tx FIFO holds 256 bytes, full ignores writes.
module hsi_status_irq (
  input wire logic clock,
  input wire logic rst_n,
  // Host register access, same clock domain.
  input wire hsi_pkg::hsi_host_req_s host_req,
  // Datapath event strobes, same clock domain.
  input wire hsi_pkg::hsi_events_s events,
  // Watermark select codes from the control register.
  input wire logic [2:0] tx_low_threshold_sel,
  input wire logic [2:0] rx_high_threshold_sel,
  // Device-level summary enable for this block.
  input wire logic master_interrupt_enable,
  // Registered read data, valid the cycle after a read strobe.
  output logic [15:0] host_rdata_ff,
  // Interrupt request pin, active high.
  output logic irq_ff,
  // One-cycle pulse asking the transmitter to send an abort.
  output logic tx_abort_send_ff
);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------

  // Threshold in bytes for a three-bit select code.
  function automatic logic [8:0] thresh_of(input logic [2:0] sel);
    logic [8:0] t;
    t = hsi_pkg::THRESH_BASE + ({6'h00, sel} * hsi_pkg::THRESH_STEP);
    return t;
  endfunction

  // Sixteen-byte level code; the full FIFO folds into the top code.
  function automatic logic [3:0] level_of(input logic [8:0] cnt);
    logic [3:0] c;
    c = (cnt >= hsi_pkg::FIFO_CAPACITY) ? hsi_pkg::LEVEL_CODE_TOP
                                         : cnt[7:4];
    return c;
  endfunction

  // ---------------------------------------------------------------
  // State declarations
  // ---------------------------------------------------------------

  // Byte counts of the two FIFOs, 0 to 256.
  logic [8:0] tx_cnt_ff, nxt_tx_cnt;
  logic [8:0] rx_cnt_ff, nxt_rx_cnt;
  // Underrun and overrun rearm flags.
  logic tx_under_arm_ff, nxt_tx_under_arm;
  logic rx_over_arm_ff, nxt_rx_over_arm;
  // Ones run counter and abort rearm flag.
  logic [2:0] ones_ff, nxt_ones;
  logic abort_arm_ff, nxt_abort_arm;
  // Abort request to the transmitter.
  logic nxt_tx_abort_send;
  // Latched event flags, at their status positions.
  logic [15:0] latch_ff, nxt_latch;
  // Interrupt enable register.
  logic [15:0] enable_ff, nxt_enable;
  logic [15:0] nxt_rdata;
  logic nxt_irq;
  // Combined status word and event decodes.
  logic [15:0] status_word;
  logic [15:0] live_word;
  logic [15:0] set_word;
  logic tx_underrun;
  logic rx_overrun;
  logic rx_abort;
  logic status_rd;
  logic enable_wr;

  // ---------------------------------------------------------------
  // FIFO tracking and event detection
  // ---------------------------------------------------------------

  // Counts follow the datapath strobes and detect the error events.
  always_comb begin
    nxt_tx_cnt = tx_cnt_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_tx_under_arm = tx_under_arm_ff;
    nxt_rx_over_arm = rx_over_arm_ff;
    nxt_ones = ones_ff;
    nxt_abort_arm = abort_arm_ff;
    tx_underrun = events.tx_fetch && (tx_cnt_ff == 9'h000) &&
                  tx_under_arm_ff;
    // A full rx FIFO that is pushed again overruns.
    rx_overrun = events.rx_push && !events.rx_pop &&
                 (rx_cnt_ff == hsi_pkg::FIFO_CAPACITY) && rx_over_arm_ff;
    // Capacity limit: a full FIFO drops writes.
    if (events.tx_push && (tx_cnt_ff < hsi_pkg::FIFO_CAPACITY)) begin
      if (!(events.tx_fetch && (tx_cnt_ff != 9'h000))) begin
        nxt_tx_cnt = tx_cnt_ff + 9'h001;
      end
    end else if (events.tx_fetch && (tx_cnt_ff != 9'h000)) begin
      nxt_tx_cnt = tx_cnt_ff - 9'h001;
    end
    // Rx count saturates too; the overflowing byte is lost.
    if (events.rx_push && (rx_cnt_ff < hsi_pkg::FIFO_CAPACITY)) begin
      if (!(events.rx_pop && (rx_cnt_ff != 9'h000))) begin
        nxt_rx_cnt = rx_cnt_ff + 9'h001;
      end
    end else if (events.rx_pop && (rx_cnt_ff != 9'h000)) begin
      nxt_rx_cnt = rx_cnt_ff - 9'h001;
    end
    // Rearm only after the FIFO has been written.
    if (tx_underrun) begin
      nxt_tx_under_arm = 1'b0;
    end else if (events.tx_push) begin
      nxt_tx_under_arm = 1'b1;
    end
    // Rearm overrun only after a FIFO read.
    if (rx_overrun) begin
      nxt_rx_over_arm = 1'b0;
    end else if (events.rx_pop) begin
      nxt_rx_over_arm = 1'b1;
    end
    // Ones run counter saturates at seven; a zero restarts it.
    if (events.rx_bit_valid) begin
      if (!events.rx_bit) begin
        nxt_ones = 3'h0;
      end else if (ones_ff != hsi_pkg::ABORT_RUN) begin
        nxt_ones = ones_ff + 3'h1;
      end
    end
    // Abort only counts during packet reception.
    rx_abort = events.rx_bit_valid && events.rx_bit &&
               (ones_ff == hsi_pkg::ABORT_RUN - 3'h1) &&
               events.rx_in_packet && abort_arm_ff;
    // Abort rearm waits for a valid flag.
    if (rx_abort) begin
      nxt_abort_arm = 1'b0;
    end else if (events.rx_flag_seen) begin
      nxt_abort_arm = 1'b1;
    end
    nxt_tx_abort_send = tx_underrun;
  end

  // Registers of the tracking group.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_cnt_ff <= 9'h000;
      rx_cnt_ff <= 9'h000;
      tx_under_arm_ff <= 1'b0;
      rx_over_arm_ff <= 1'b1;
      ones_ff <= 3'h0;
      abort_arm_ff <= 1'b1;
      tx_abort_send_ff <= 1'b0;
    end else begin
      tx_cnt_ff <= nxt_tx_cnt;
      rx_cnt_ff <= nxt_rx_cnt;
      tx_under_arm_ff <= nxt_tx_under_arm;
      rx_over_arm_ff <= nxt_rx_over_arm;
      ones_ff <= nxt_ones;
      abort_arm_ff <= nxt_abort_arm;
      tx_abort_send_ff <= nxt_tx_abort_send;
    end
  end

  // ---------------------------------------------------------------
  // Status, enable and interrupt registers
  // ---------------------------------------------------------------

  // Live bits, latched flags, host access and the interrupt request.
  always_comb begin
    live_word = 16'h0000;
    set_word = 16'h0000;
    status_rd = host_req.rd &&
                (host_req.addr == hsi_pkg::HDLC_EVENT_STATUS_OFS);
    enable_wr = host_req.wr &&
                (host_req.addr == hsi_pkg::HDLC_EVENT_ENABLE_OFS);
    // Tx low flag, with threshold decode.
    live_word[hsi_pkg::TX_LOW_LEVEL_BIT] =
      (tx_cnt_ff < thresh_of(tx_low_threshold_sel));
    // Rx high flag, using the same threshold decode.
    live_word[hsi_pkg::RX_HIGH_LEVEL_BIT] =
      (rx_cnt_ff > thresh_of(rx_high_threshold_sel));
    live_word[hsi_pkg::TX_LEVEL_LSB +: 4] = level_of(tx_cnt_ff);
    live_word[hsi_pkg::TX_VACANT_BIT] = (tx_cnt_ff == 9'h000);
    live_word[hsi_pkg::RX_VACANT_BIT] = (rx_cnt_ff == 9'h000);
    // Packet end on tagged fetch or on underrun.
    set_word[hsi_pkg::TX_PACKET_DONE_BIT] =
      (events.tx_fetch && events.tx_fetch_last &&
       (tx_cnt_ff != 9'h000)) || tx_underrun;
    set_word[hsi_pkg::RX_PACKET_BEGIN_BIT] = events.rx_open_byte;
    set_word[hsi_pkg::RX_PACKET_DONE_BIT] = events.rx_msg_end;
    set_word[hsi_pkg::TX_UNDERFLOW_BIT] = tx_underrun;
    set_word[hsi_pkg::RX_OVERFLOW_BIT] = rx_overrun;
    set_word[hsi_pkg::RX_ABORT_BIT] = rx_abort;
    status_word = live_word | latch_ff;
    // Read clears, a same-cycle event wins.
    nxt_latch = (status_rd ? 16'h0000 : latch_ff) | set_word;
    // Only the capable bits are writable enables.
    nxt_enable = enable_wr ? (host_req.wdata & hsi_pkg::IRQ_CAPABLE_MASK)
                           : enable_ff;
    // Unmapped reads return zero.
    if (host_req.rd &&
        (host_req.addr == hsi_pkg::HDLC_EVENT_STATUS_OFS)) begin
      nxt_rdata = status_word;
    end else if (host_req.rd &&
                 (host_req.addr == hsi_pkg::HDLC_EVENT_ENABLE_OFS)) begin
      nxt_rdata = enable_ff;
    end else begin
      nxt_rdata = 16'h0000;
    end
    // OR of enabled flags, capable bits only
    // then the summary enable gates it.
    nxt_irq = (|(status_word & enable_ff & hsi_pkg::IRQ_CAPABLE_MASK)) &&
              master_interrupt_enable;
  end

  // Registers of the host-facing group.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      latch_ff <= 16'h0000;
      enable_ff <= hsi_pkg::ENABLE_RESET;
      host_rdata_ff <= 16'h0000;
      irq_ff <= 1'b0;
    end else begin
      latch_ff <= nxt_latch;
      enable_ff <= nxt_enable;
      host_rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // A latched packet start flag with no new event is gone after a status read.
  read_clears_a: assert property (
    (status_rd && !set_word[hsi_pkg::RX_PACKET_BEGIN_BIT])
    |=> !latch_ff[hsi_pkg::RX_PACKET_BEGIN_BIT])
    else $error("packet start flag survived a read");

  // An event in the read cycle is still seen by the next read.
  set_wins_a: assert property (
    (status_rd && events.rx_msg_end)
    |=> latch_ff[hsi_pkg::RX_PACKET_DONE_BIT])
    else $error("event lost in read cycle");

  // Underrun pulses the abort request and latches both flags.
  underrun_abort_a: assert property (
    tx_underrun |=> tx_abort_send_ff &&
    latch_ff[hsi_pkg::TX_UNDERFLOW_BIT] &&
    latch_ff[hsi_pkg::TX_PACKET_DONE_BIT])
    else $error("underrun did not abort and latch");

  // No second underrun without an intervening write.
  underrun_rearm_a: assert property (
    (tx_underrun ##1 (!events.tx_push)[*3]) |-> !tx_under_arm_ff)
    else $error("underrun rearmed without a write");

  // Status read returns the tx depth code and vacant flag.
  tx_level_read_a: assert property (
    status_rd |=> (host_rdata_ff[hsi_pkg::TX_LEVEL_LSB +: 4] ==
                   level_of($past(tx_cnt_ff))) &&
                  (host_rdata_ff[hsi_pkg::TX_VACANT_BIT] ==
                   ($past(tx_cnt_ff) == 9'h000)))
    else $error("tx level code wrong on read");

  // A full tx FIFO keeps its count when pushed without a fetch.
  tx_full_hold_a: assert property (
    (tx_cnt_ff == hsi_pkg::FIFO_CAPACITY && events.tx_push &&
     !events.tx_fetch) |=> tx_cnt_ff == hsi_pkg::FIFO_CAPACITY)
    else $error("full tx FIFO accepted a write");

  // Interrupt follows enabled flags and the summary enable.
  irq_gate_a: assert property (
    irq_ff == $past((|(status_word & enable_ff)) &&
                    master_interrupt_enable))
    else $error("interrupt pin disagrees with flags");

  // Summary enable low keeps the pin low.
  irq_master_a: assert property (
    !master_interrupt_enable |=> !irq_ff)
    else $error("interrupt raised while summary disabled");

  // Enable writes keep only the capable positions.
  enable_write_a: assert property (
    enable_wr |=> enable_ff ==
                  ($past(host_req.wdata) & hsi_pkg::IRQ_CAPABLE_MASK))
    else $error("enable register write wrong");

  // While disarmed and no flag arrives, no abort and no rearm.
  // The run counter alone cannot hide a broken rearm here.
  abort_rearm_a: assert property (
    (!abort_arm_ff && !events.rx_flag_seen) |->
    !rx_abort ##1 !abort_arm_ff)
    else $error("abort flagged twice without a flag");

  // A flagged abort disarms the detector until the next flag.
  abort_disarm_a: assert property (
    rx_abort |=> !abort_arm_ff)
    else $error("abort detector stayed armed");

  // A disarmed overrun needs a FIFO read before it can fire.
  overrun_rearm_a: assert property (
    (!rx_over_arm_ff && !events.rx_pop) |->
    !rx_overrun ##1 !rx_over_arm_ff)
    else $error("overrun rearmed without a read");

  // Abort is only flagged while a packet is being received.
  abort_in_packet_a: assert property (
    rx_abort |-> events.rx_in_packet && (ones_ff == 3'h6))
    else $error("abort outside packet or wrong run");

  // Rx high flag reads back against the chosen threshold.
  rx_high_read_a: assert property (
    status_rd |=> host_rdata_ff[hsi_pkg::RX_HIGH_LEVEL_BIT] ==
      ($past(rx_cnt_ff) > thresh_of($past(rx_high_threshold_sel))))
    else $error("rx high flag wrong on read");

endmodule
`default_nettype wire

// file: verif/hsi_status_irq_test.sv
// Self-checking testbench for the HDLC status and interrupt logic.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module hsi_status_irq_test;
  // ---------------------------------------------------------------
  // Stimulus, observed outputs and the bench's own model state
  // ---------------------------------------------------------------
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  hsi_pkg::hsi_host_req_s host_req = '0;
  hsi_pkg::hsi_events_s events = '0;
  logic [2:0] tx_low_threshold_sel = 3'h0;
  logic [2:0] rx_high_threshold_sel = 3'h0;
  logic master_interrupt_enable = 1'b0;
  logic [15:0] host_rdata;
  logic irq;
  logic tx_abort_send;
  int miscompares = 0;
  int n_tests = 0;
  // Expected FIFO fill counts, tracked independently of the design.
  int txc = 0;
  int rxc = 0;
  // Latched status bits the next status read should show.
  logic [15:0] latch = 16'h0000;

  // The clock toggles every half period of 5 ns.
  always #5 clock = ~clock;

  hsi_status_irq dut (
    .clock(clock),
    .rst_n(rst_n),
    .host_req(host_req),
    .events(events),
    .tx_low_threshold_sel(tx_low_threshold_sel),
    .rx_high_threshold_sel(rx_high_threshold_sel),
    .master_interrupt_enable(master_interrupt_enable),
    .host_rdata_ff(host_rdata),
    .irq_ff(irq),
    .tx_abort_send_ff(tx_abort_send)
  );

  // ---------------------------------------------------------------
  // Host access and event tasks
  // ---------------------------------------------------------------
  // Live status bits worked out from the expected counts and selects.
  function automatic logic [15:0] live(input int t, input int r);
    logic [15:0] s;
    s = 16'h0000;
    s[2] = t < 16 + 32 * int'(tx_low_threshold_sel);
    s[4] = r > 16 + 32 * int'(rx_high_threshold_sel);
    // The top code also covers a completely full FIFO of 256 bytes.
    s[11:8] = (t >= 240) ? 4'hF : 4'(t / 16);
    s[12] = (t == 0);
    s[14] = (r == 0);
    return s;
  endfunction

  // Read data is sampled 1 ns after the edge that takes the strobe.
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    host_req.addr <= a;
    host_req.rd <= 1'b1;
    @(posedge clock);
    host_req.rd <= 1'b0;
    #1 d = host_rdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clock);
    host_req.addr <= a;
    host_req.wdata <= v;
    host_req.wr <= 1'b1;
    @(posedge clock);
    host_req.wr <= 1'b0;
  endtask

  // Reading status clears the latched part of the expectation too.
  task automatic chk_status();
    logic [15:0] d;
    rd(hsi_pkg::HDLC_EVENT_STATUS_OFS, d);
    `CHK(d, live(txc, rxc) | latch)
    latch = 16'h0000;
  endtask

  // Presents one strobe pattern for n back-to-back cycles.
  task automatic ev(input hsi_pkg::hsi_events_s e, input int n);
    repeat (n) begin
      @(posedge clock);
      events <= e;
    end
    @(posedge clock);
    events <= '0;
  endtask

  // Walks every threshold select code at the present fill level.
  task automatic sweep();
    for (int s = 0; s < 8; s++) begin
      @(posedge clock);
      tx_low_threshold_sel <= 3'(s);
      rx_high_threshold_sel <= 3'(s);
      chk_status();
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Guard against a hang; the full sequence needs about 14k cycles.
  initial begin
    repeat (60000) @(posedge clock);
    miscompares++;
    stop_test();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    hsi_pkg::hsi_events_s e;
    logic [15:0] d;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    // Reset values, enable masking, ignored and unmapped accesses.
    chk_status();
    rd(hsi_pkg::HDLC_EVENT_ENABLE_OFS, d);
    `CHK(d, 16'h0000)
    wr(hsi_pkg::HDLC_EVENT_ENABLE_OFS, 16'hFFFF);
    rd(hsi_pkg::HDLC_EVENT_ENABLE_OFS, d);
    `CHK(d, 16'hA0F5)
    wr(hsi_pkg::HDLC_EVENT_STATUS_OFS, 16'hFFFF);
    wr(hsi_pkg::HDLC_EVENT_ENABLE_OFS, 16'h0000);
    rd(8'h10, d);
    `CHK(d, 16'h0000)
    chk_status();
    $display("test registers done");
    // Fill the tx FIFO past capacity; extra writes are dropped.
    e = '0;
    e.tx_push = 1'b1;
    for (int i = 1; i <= 258; i++) begin
      ev(e, 1);
      if (txc < 256) txc++;
      sweep();
    end
    // Fill the rx FIFO to capacity; watch the high-level flag.
    e = '0;
    e.rx_push = 1'b1;
    for (int i = 1; i <= 256; i++) begin
      ev(e, 1);
      rxc++;
      sweep();
    end
    $display("test levels done");
    // Overrun latches once, then needs a pop before it rearms.
    ev(e, 1);
    latch[13] = 1'b1;
    chk_status();
    ev(e, 1);
    chk_status();
    e.rx_pop = 1'b1;
    e.rx_push = 1'b0;
    ev(e, 1);
    e.rx_pop = 1'b0;
    e.rx_push = 1'b1;
    ev(e, 2);
    latch[13] = 1'b1;
    chk_status();
    e = '0;
    e.rx_pop = 1'b1;
    ev(e, 256);
    rxc = 0;
    $display("test overrun done");
    // Drain tx; the tagged last byte marks the packet end.
    e = '0;
    e.tx_fetch = 1'b1;
    ev(e, 255);
    e.tx_fetch_last = 1'b1;
    ev(e, 1);
    txc = 0;
    latch[0] = 1'b1;
    chk_status();
    // Fetch from an empty FIFO after writes: underrun and abort.
    e.tx_fetch_last = 1'b0;
    ev(e, 1);
    #1 `CHK(tx_abort_send, 1'b1)
    latch = 16'h0081;
    chk_status();
    ev(e, 1);
    #1 `CHK(tx_abort_send, 1'b0)
    chk_status();
    $display("test transmit done");
    // Packet start and end latch; an event during a read survives.
    e = '0;
    e.rx_open_byte = 1'b1;
    ev(e, 1);
    latch[5] = 1'b1;
    chk_status();
    e = '0;
    e.rx_msg_end = 1'b1;
    @(posedge clock);
    events <= e;
    host_req.addr <= hsi_pkg::HDLC_EVENT_STATUS_OFS;
    host_req.rd <= 1'b1;
    @(posedge clock);
    events <= '0;
    host_req.rd <= 1'b0;
    latch[6] = 1'b1;
    chk_status();
    // Abort needs seven ones inside a packet, then a flag to rearm.
    e = '0;
    e.rx_bit_valid = 1'b1;
    e.rx_bit = 1'b1;
    ev(e, 7);
    chk_status();
    e.rx_in_packet = 1'b1;
    ev(e, 6);
    e.rx_bit = 1'b0;
    ev(e, 1);
    chk_status();
    e.rx_bit = 1'b1;
    ev(e, 7);
    latch[15] = 1'b1;
    chk_status();
    // A zero restarts the run, so only the missing flag can block it.
    e.rx_bit = 1'b0;
    ev(e, 1);
    e.rx_bit = 1'b1;
    ev(e, 7);
    chk_status();
    // The flag's closing zero both rearms and restarts the run.
    e.rx_flag_seen = 1'b1;
    e.rx_bit = 1'b0;
    ev(e, 1);
    e.rx_flag_seen = 1'b0;
    e.rx_bit = 1'b1;
    ev(e, 7);
    latch[15] = 1'b1;
    chk_status();
    $display("test receive done");
    // Interrupt needs the bit enable and the summary enable.
    wr(hsi_pkg::HDLC_EVENT_ENABLE_OFS, 16'h5F0A);
    @(posedge clock);
    master_interrupt_enable <= 1'b1;
    repeat (3) @(posedge clock);
    #1 `CHK(irq, 1'b0)
    wr(hsi_pkg::HDLC_EVENT_ENABLE_OFS, 16'h0020);
    e = '0;
    e.rx_open_byte = 1'b1;
    ev(e, 1);
    repeat (2) @(posedge clock);
    #1 `CHK(irq, 1'b1)
    latch[5] = 1'b1;
    chk_status();
    repeat (2) @(posedge clock);
    #1 `CHK(irq, 1'b0)
    // A live flag drives the request while its enable is set.
    wr(hsi_pkg::HDLC_EVENT_ENABLE_OFS, 16'h0004);
    repeat (3) @(posedge clock);
    #1 `CHK(irq, 1'b1)
    @(posedge clock);
    master_interrupt_enable <= 1'b0;
    repeat (3) @(posedge clock);
    #1 `CHK(irq, 1'b0)
    $display("test interrupt done");
    stop_test();
  end
endmodule
`default_nettype wire
